// ==== common/gcsl_map.vh ====
`ifndef GCSL_MAP_VH
`define GCSL_MAP_VH

// register offset and reset value
`define GCSL_GCFG_ADDR 8'h00
`define GCSL_GCFG_RESET 8'h00
// field positions
`define GCSL_DBG_DIS_BIT 0
`define GCSL_WAKE_SEL_BIT 1
// stack defaults
`define GCSL_RAM_END 16'h03ff
`define GCSL_ROLL_LIMIT 16'h0200

`endif

// ==== core/gcsl_global_config.v ====
// Overview of operation
// R1: reset clears whole configuration register
// R2: bit 0 one frees debug pin
// R3: debug mode keeps pin from gpio
// R4: wake select zero returns to main
// R5: wake select one returns to wait
// R6: both fields software read and write
// R7: bits 7 to 2 read zero
// R8: push below limit reloads ram end
// R9: pointer arithmetic never rolls over
// R10: limit and ram end are parameters
`timescale 1ns/1ps
`default_nettype none
`include "gcsl_map.vh"

module gcsl_global_config #(
  parameter [15:0] RAM_END = `GCSL_RAM_END,
  parameter [15:0] ROLL_LIMIT = `GCSL_ROLL_LIMIT,
  parameter ROLL_EN = 1
) (
  // clock and reset
  input wire mclk_in,
  input wire srst_in,
  // register port
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  // debug pin sharing
  input wire gpio_req_in,
  input wire gpio_o_in,
  input wire gpio_oe_n_in,
  output reg pin_o_out,
  output reg pin_oe_n_out,
  output reg single_wire_debug_link_en_out,
  // interrupt return
  input wire interrupt_return_instr_in,
  output reg resume_main_out,
  output reg reenter_wait_out,
  // stack pointer update
  input wire sp_push_in,
  input wire sp_arith_in,
  input wire [15:0] sp_next_in,
  output reg [15:0] sp_out
);

  // field positions and reset image of the configuration register
  // limitation: one mapped register, so decode is a single compare
  localparam integer WAKE_BIT = `GCSL_WAKE_SEL_BIT;
  localparam integer DBG_BIT = `GCSL_DBG_DIS_BIT;
  localparam [7:0] GCFG_ADDR = `GCSL_GCFG_ADDR;
  localparam [7:0] GCFG_RST = `GCSL_GCFG_RESET;
  // reset value of the two live fields
  localparam [0:0] WAKE_RST = GCFG_RST[WAKE_BIT];
  localparam [0:0] DBG_RST = GCFG_RST[DBG_BIT];
  // pin levels while the debug link keeps the pin
  localparam [0:0] PIN_IDLE = 1'b0;
  localparam [0:0] OE_N_OFF = 1'b1;

  // configuration fields, written only by software
  reg wake_sel_r;
  reg wake_sel_nxt;
  reg dbg_dis_r;
  reg dbg_dis_nxt;

  // bus decode for the single mapped offset
  wire gcfg_hit;
  wire gcfg_wr;
  wire gcfg_rd;

  // read path
  reg [7:0] gcfg_image;
  reg [7:0] rdata_nxt;

  // pin sharing between debug link and gpio
  wire gpio_owns_pin;
  reg link_en_nxt;
  reg pin_o_nxt;
  reg pin_oe_n_nxt;

  // interrupt return actions
  reg resume_nxt;
  reg reenter_nxt;

  // stack pointer
  wire roll_on;
  wire roll_hit;
  reg [15:0] sp_nxt;

  // other offsets are ignored on write and read as zero
  assign gcfg_hit = (addr_in == GCFG_ADDR);
  assign gcfg_wr = wr_in & gcfg_hit;
  assign gcfg_rd = rd_in & gcfg_hit;

  // configuration next value, software is the only writer
  always @* begin
    wake_sel_nxt = wake_sel_r;
    dbg_dis_nxt = dbg_dis_r;
    if (gcfg_wr) begin
      wake_sel_nxt = wdata_in[WAKE_BIT]; // [R6]
      dbg_dis_nxt = wdata_in[DBG_BIT]; // [R6]
    end
  end

  // configuration register, cleared by reset
  always @(posedge mclk_in) begin
    if (srst_in) begin
      wake_sel_r <= WAKE_RST; // [R1]
      dbg_dis_r <= DBG_RST; // [R1]
    end else begin
      wake_sel_r <= wake_sel_nxt;
      dbg_dis_r <= dbg_dis_nxt;
    end
  end

  // image as software sees it, reserved bits held low
  always @* begin
    gcfg_image = 8'h00; // [R7]
    gcfg_image[WAKE_BIT] = wake_sel_r; // [R6]
    gcfg_image[DBG_BIT] = dbg_dis_r; // [R6]
  end

  // read data stands one cycle after the strobe, zero otherwise
  always @* begin
    rdata_nxt = 8'h00; // [R7]
    if (gcfg_rd) begin
      rdata_nxt = gcfg_image;
    end
  end

  // registered read data
  always @(posedge mclk_in) begin
    if (srst_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= rdata_nxt;
    end
  end

  // gpio gets the pin only once the debug link is disabled
  assign gpio_owns_pin = dbg_dis_r & gpio_req_in; // [R3]

  // pin mux next value, a port request alone never wins
  // hazard: gpio must never fight the debug tool on the pin
  always @* begin
    link_en_nxt = ~dbg_dis_r; // [R2]
    pin_o_nxt = PIN_IDLE; // [R3]
    pin_oe_n_nxt = OE_N_OFF; // [R3]
    if (gpio_owns_pin) begin
      pin_o_nxt = gpio_o_in; // [R2]
      pin_oe_n_nxt = gpio_oe_n_in; // [R2]
    end
  end

  // registered so the pin never sees a decode glitch
  always @(posedge mclk_in) begin
    if (srst_in) begin
      single_wire_debug_link_en_out <= ~DBG_RST; // [R1]
      pin_o_out <= PIN_IDLE;
      pin_oe_n_out <= OE_N_OFF;
    end else begin
      single_wire_debug_link_en_out <= link_en_nxt;
      pin_o_out <= pin_o_nxt;
      pin_oe_n_out <= pin_oe_n_nxt;
    end
  end

  // one pulse per executed return, chosen by the wake field
  // re-entry skips the context restore entirely
  always @* begin
    resume_nxt = 1'b0;
    reenter_nxt = 1'b0;
    if (interrupt_return_instr_in) begin
      if (wake_sel_r) begin
        reenter_nxt = 1'b1; // [R5]
      end else begin
        resume_nxt = 1'b1; // [R4]
      end
    end
  end

  // registered return actions, no stack pop on re-entry
  always @(posedge mclk_in) begin
    if (srst_in) begin
      resume_main_out <= 1'b0;
      reenter_wait_out <= 1'b0;
    end else begin
      resume_main_out <= resume_nxt;
      reenter_wait_out <= reenter_nxt;
    end
  end

  // roll-over exists only when the build enables it
  assign roll_on = (ROLL_EN != 0); // [R10]
  // strictly below the limit counts as running off the stack
  assign roll_hit = roll_on & (sp_next_in < ROLL_LIMIT); // [R8]

  // next pointer, push wins over arithmetic
  // arithmetic never reloads, even far below the limit
  always @* begin
    sp_nxt = sp_out;
    if (sp_push_in) begin
      if (roll_hit) begin
        sp_nxt = RAM_END; // [R8] [R10]
      end else begin
        sp_nxt = sp_next_in;
      end
    end else if (sp_arith_in) begin
      sp_nxt = sp_next_in; // [R9] no roll-over here
    end
  end

  // stack pointer register, starts at the ram end
  always @(posedge mclk_in) begin
    if (srst_in) begin
      sp_out <= RAM_END;
    end else begin
      sp_out <= sp_nxt;
    end
  end

endmodule
`default_nettype wire

// ==== sim/gcsl_global_config_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// port watcher for the config block
module gcsl_chk #(parameter [15:0] RAM_END=0,ROLL_LIMIT=0)(
  input wire mclk_in,srst_in,rd_in,pin_oe_n_out,sp_push_in,sp_arith_in,
  input wire interrupt_return_instr_in,resume_main_out,reenter_wait_out,
  input wire single_wire_debug_link_en_out,
  input wire [7:0] addr_in,rdata_out,
  input wire [15:0] sp_next_in,sp_out);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  rst_state_a: assert property ($fell(srst_in) |->
    single_wire_debug_link_en_out&&sp_out==RAM_END) else $error("rst");
  dbg_bit_a: assert property ($past(rd_in&&addr_in==0) |->
    rdata_out[0]!=single_wire_debug_link_en_out) else $error("dbg");
  pin_hold_a: assert property (single_wire_debug_link_en_out |->
    pin_oe_n_out) else $error("pin");
  wake_one_a: assert property (interrupt_return_instr_in |=>
    resume_main_out^reenter_wait_out) else $error("wake");
  unmap_zero_a: assert property (rd_in&&addr_in!=0 |=>
    rdata_out==0) else $error("unmap");
  sp_roll_a: assert property (sp_push_in&&sp_next_in<ROLL_LIMIT |=>
    sp_out==RAM_END) else $error("roll");
  sp_push_a: assert property (sp_push_in&&sp_next_in>=ROLL_LIMIT |=>
    sp_out==$past(sp_next_in)) else $error("push");
  sp_arith_a: assert property (sp_arith_in&&!sp_push_in |=>
    sp_out==$past(sp_next_in)) else $error("arith");
endmodule
bind gcsl_global_config gcsl_chk #(.RAM_END(RAM_END),
  .ROLL_LIMIT(ROLL_LIMIT)) chk(.mclk_in(mclk_in),.srst_in(srst_in),
  .rd_in(rd_in),.pin_oe_n_out(pin_oe_n_out),.sp_push_in(sp_push_in),
  .sp_arith_in(sp_arith_in),
  .interrupt_return_instr_in(interrupt_return_instr_in),
  .resume_main_out(resume_main_out),.reenter_wait_out(reenter_wait_out),
  .single_wire_debug_link_en_out(single_wire_debug_link_en_out),
  .addr_in(addr_in),.rdata_out(rdata_out),.sp_next_in(sp_next_in),
  .sp_out(sp_out));
`default_nettype wire

// ==== sim/global_config_stack_limit_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "gcsl_map.vh"
module global_config_stack_limit_tb_top;
  logic mclk_in=0,srst_in=1,wr_in=0,rd_in=0,gpio_req_in=0,gpio_o_in=0;
  logic gpio_oe_n_in=0,interrupt_return_instr_in=0,sp_push_in=0;
  logic sp_arith_in=0,pin_o_out,pin_oe_n_out,single_wire_debug_link_en_out;
  logic resume_main_out,reenter_wait_out,p;
  logic [1:0] wk;
  logic [7:0] addr_in=0,wdata_in=0,rdata_out,d;
  logic [15:0] sp_next_in=0,sp_out,s;
  int fail_count=0,checks_done=0,cyc=0;
  gcsl_global_config dut(.mclk_in(mclk_in),.srst_in(srst_in),
    .addr_in(addr_in),.wdata_in(wdata_in),.wr_in(wr_in),.rd_in(rd_in),
    .rdata_out(rdata_out),.gpio_req_in(gpio_req_in),.gpio_o_in(gpio_o_in),
    .gpio_oe_n_in(gpio_oe_n_in),.pin_o_out(pin_o_out),
    .pin_oe_n_out(pin_oe_n_out),
    .single_wire_debug_link_en_out(single_wire_debug_link_en_out),
    .interrupt_return_instr_in(interrupt_return_instr_in),
    .resume_main_out(resume_main_out),.reenter_wait_out(reenter_wait_out),
    .sp_push_in(sp_push_in),.sp_arith_in(sp_arith_in),
    .sp_next_in(sp_next_in),.sp_out(sp_out));
  always #25 mclk_in=~mclk_in;
  // hang guard
  always @(posedge mclk_in) begin
    cyc<=cyc+1;
    if(cyc>2000) begin
      fail_count++;
      end_of_test;
    end
  end
  task chk(string n,logic [15:0] e,g);
    checks_done++;
    if(g!==e) begin
      fail_count++;
      $display("ERROR %s exp %h got %h",n,e,g);
    end
  endtask
  // expected values from the rules and the map constants
  function automatic logic [15:0] exp_sp(logic push,logic [15:0] nx);
    return (push&&nx<`GCSL_ROLL_LIMIT)?`GCSL_RAM_END:nx;
  endfunction
  function automatic logic [1:0] exp_wake(logic sel);
    return sel?2'b10:2'b01;
  endfunction
  function automatic logic exp_oe(logic gpio,logic oe_n);
    return gpio?oe_n:1'b1;
  endfunction
  // one bus cycle; a read compares against v
  task bus(logic w,logic [7:0] a,v);
    @(posedge mclk_in);
    {addr_in,wdata_in,wr_in,rd_in}<={a,v,w,!w};
    @(posedge mclk_in);
    {wr_in,rd_in}<=0;
    #1 if(!w) chk("rdata",v,rdata_out);
  endtask
  initial begin
    void'($urandom(32'hebc7));
    repeat(12) @(posedge mclk_in);
    srst_in<=0;
    #1 chk("sp",`GCSL_RAM_END,sp_out);
    bus(0,0,0);
    for(int i=0;i<40;i++) begin
      d=$urandom;
      p=i<2||d[4];
      s=i<2?`GCSL_ROLL_LIMIT-i:$urandom_range(1023);
      bus(1,0,d&8'h03);
      bus(1,1,~d);
      bus(0,0,d&3);
      bus(0,2,0);
      @(posedge mclk_in);
      {interrupt_return_instr_in,sp_push_in,sp_arith_in}<={1'b1,p,!p||d[6]};
      {sp_next_in,gpio_req_in,gpio_o_in,gpio_oe_n_in}<={s,d[2],d[3],d[5]};
      @(posedge mclk_in);
      {interrupt_return_instr_in,sp_push_in,sp_arith_in}<=0;
      #1 wk={reenter_wait_out,resume_main_out};
      chk("wake",exp_wake(d[1]),wk);
      chk("sp",exp_sp(p,s),sp_out);
      chk("pin_oe",exp_oe(d[0]&d[2],d[5]),pin_oe_n_out);
      chk("pin_o",d[0]&d[2]&d[3],pin_o_out);
      chk("dbg",!d[0],single_wire_debug_link_en_out);
    end
    // mid-run reset with the debug link disabled beforehand
    bus(1,0,3);
    @(posedge mclk_in) srst_in<=1;
    repeat(2) @(posedge mclk_in);
    srst_in<=0;
    #1 chk("dbg",1,single_wire_debug_link_en_out);
    chk("pin_oe",1,pin_oe_n_out);
    bus(0,0,0);
    end_of_test;
  end
  task end_of_test;
    $display("checks %0d mismatches %0d",checks_done,fail_count);
    if(fail_count==0&&checks_done>0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
endmodule
`default_nettype wire
